// File: verilog/tco_regs.vh
`ifndef TCO_REGS_VH
`define TCO_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TCO_IDX_A_CMPB_LO 10'h09A
`define TCO_IDX_A_CMPB_HI 10'h09B
`define TCO_IDX_B_CTRL_A 10'h0A0
`define TCO_IDX_B_CTRL_B 10'h0A1
`define TCO_IDX_B_CMPA_LO 10'h0A8
`define TCO_IDX_B_CMPA_HI 10'h0A9
`define TCO_IDX_B_CMPB_LO 10'h0AA
`define TCO_IDX_B_CMPB_HI 10'h0AB
`define TCO_IDX_A_MODE 10'h0AC
`define TCO_IDX_IRQ_STATUS 10'h0AD
`define TCO_IDX_IRQ_MASK 10'h0AE

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TCO_CHA_MODE_HI 7
`define TCO_CHA_MODE_LO 6
`define TCO_CHB_MODE_HI 5
`define TCO_CHB_MODE_LO 4
`define TCO_WAVE_LOW_HI 1
`define TCO_WAVE_LOW_LO 0
`define TCO_WAVE_UP_HI 4
`define TCO_WAVE_UP_LO 3
`define TCO_IRQ_A_CMPB 0
`define TCO_IRQ_B_CMPA 1
`define TCO_IRQ_B_CMPB 2

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define TCO_RST_BYTE 8'h00
`define TCO_RST_WORD 16'h0000
`define TCO_RST_IRQ 3'h0
`define TCO_RESP_OKAY 2'h0
`define TCO_RESP_SLVERR 2'h2
`define TCO_MODE_OFF 2'h0
`define TCO_MODE_TOGGLE 2'h1
`define TCO_MODE_CLEAR 2'h2
`define TCO_MODE_SET 2'h3

`endif

// File: verilog/tco_ctrl.v
// Function
// - Timer A channel B compare value is matched against its counter.
// - Both compare bytes update together via shared high-byte temp.
// - Control A: chan A mode 7:6, chan B mode 5:4, wave 1:0.
// - Nonzero mode field lets compare output override port function, except PWM mode 01 where toggle is unavailable.
// - Pin driver enabled only when port direction bit is set.
// - Channel B outputs also need port D bit 2 unless modulated.
// - Non-PWM: off, toggle, clear, set on compare match.
// - Fast PWM: 10 non-inverting, 11 inverting with BOTTOM action.
// - Fast PWM mode 01: toggle A only in waveform modes 14, 15.
// - Fast PWM match at TOP ignored when upper mode bit set.
// - Phase PWM mode 01: toggle A only in waveform modes 9, 11.
// - Phase PWM: action depends on counting direction at match.
// - Four-bit waveform mode picks sequence, TOP and waveform; here it picks the waveform only, TOP and count direction are inputs.
// - Upper waveform bits sit in control B bits 4 and 3.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`include "tco_regs.vh"

module tco_ctrl (
  input wire clk_in,
  input wire nrst_in,
  input wire [11:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [11:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire timer_a_tick_in,
  input wire [15:0] timer_a_counter_in,
  input wire timer_b_tick_in,
  input wire [15:0] timer_b_counter_in,
  input wire [15:0] timer_b_top_in,
  input wire timer_b_count_up_in,
  input wire port_dir_b_out_a_in,
  input wire port_dir_b_out_b_in,
  input wire port_dir_a_out_b_in,
  input wire port_d_bit2_output_in,
  input wire modulator_in_use_in,
  output reg timer_b_out_a_out,
  output reg timer_b_out_a_override_out,
  output reg timer_b_out_a_oe_out,
  output reg timer_b_out_b_out,
  output reg timer_b_out_b_override_out,
  output reg timer_b_out_b_oe_out,
  output reg timer_a_out_b_out,
  output reg timer_a_out_b_override_out,
  output reg timer_a_out_b_oe_out,
  output reg irq_out
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [7:0] timer_b_control_a;
  reg [7:0] timer_b_control_b;
  reg [7:0] high_byte_temp;
  reg [15:0] timer_a_compare_b_value;
  reg [15:0] timer_b_compare_a_value;
  reg [15:0] timer_b_compare_b_value;
  reg [1:0] timer_a_b_mode;
  reg [2:0] irq_status;
  reg [2:0] irq_mask;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  reg aw_full;
  reg w_full;
  reg [9:0] wr_idx;
  reg [7:0] wr_data;
  reg wr_lane0;
  wire wr_en;
  reg wr_hit;

  assign wr_en = aw_full & w_full & ~s_axi_bvalid_out;

  always @* begin
    if (wr_idx == `TCO_IDX_A_CMPB_LO) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `TCO_IDX_A_CMPB_HI) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `TCO_IDX_B_CTRL_A) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `TCO_IDX_B_CTRL_B) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `TCO_IDX_B_CMPA_LO) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `TCO_IDX_B_CMPA_HI) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `TCO_IDX_B_CMPB_LO) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `TCO_IDX_B_CMPB_HI) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `TCO_IDX_A_MODE) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `TCO_IDX_IRQ_STATUS) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `TCO_IDX_IRQ_MASK) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wr_idx <= 10'h000;
      wr_data <= `TCO_RST_BYTE;
      wr_lane0 <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `TCO_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full <= 1'b1;
        wr_idx <= s_axi_awaddr_in[11:2];
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full <= 1'b1;
        wr_data <= s_axi_wdata_in[7:0];
        wr_lane0 <= s_axi_wstrb_in[0];
        s_axi_wready_out <= 1'b0;
      end
      if (wr_en) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_hit ? `TCO_RESP_OKAY : `TCO_RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare match detection
  // ----------------------------------------------------------------
  wire a_match;
  wire [1:0] b_match;
  wire [2:0] irq_events;
  wire wr_do;

  assign wr_do = wr_en & wr_lane0;
  assign a_match = timer_a_tick_in &
    (timer_a_counter_in == timer_a_compare_b_value);
  assign b_match[0] = timer_b_tick_in &
    (timer_b_counter_in == timer_b_compare_a_value);
  assign b_match[1] = timer_b_tick_in &
    (timer_b_counter_in == timer_b_compare_b_value);
  assign irq_events = {b_match[1], b_match[0], a_match};

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // High byte only lands in the temp; the low byte write commits both
  // halves in one edge, so the comparator never sees a torn value.
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_b_control_a <= `TCO_RST_BYTE;
      timer_b_control_b <= `TCO_RST_BYTE;
      high_byte_temp <= `TCO_RST_BYTE;
      timer_a_compare_b_value <= `TCO_RST_WORD;
      timer_b_compare_a_value <= `TCO_RST_WORD;
      timer_b_compare_b_value <= `TCO_RST_WORD;
      timer_a_b_mode <= `TCO_MODE_OFF;
      irq_mask <= `TCO_RST_IRQ;
    end else if (wr_do) begin
      if (wr_idx == `TCO_IDX_B_CTRL_A) begin
        timer_b_control_a <= wr_data & 8'hF3;
      end else if (wr_idx == `TCO_IDX_B_CTRL_B) begin
        timer_b_control_b <= wr_data;
      end else if (wr_idx == `TCO_IDX_A_CMPB_HI ||
                   wr_idx == `TCO_IDX_B_CMPA_HI ||
                   wr_idx == `TCO_IDX_B_CMPB_HI) begin
        high_byte_temp <= wr_data;
      end else if (wr_idx == `TCO_IDX_A_CMPB_LO) begin
        timer_a_compare_b_value <= {high_byte_temp, wr_data};
      end else if (wr_idx == `TCO_IDX_B_CMPA_LO) begin
        timer_b_compare_a_value <= {high_byte_temp, wr_data};
      end else if (wr_idx == `TCO_IDX_B_CMPB_LO) begin
        timer_b_compare_b_value <= {high_byte_temp, wr_data};
      end else if (wr_idx == `TCO_IDX_A_MODE) begin
        timer_a_b_mode <= wr_data[1:0];
      end else if (wr_idx == `TCO_IDX_IRQ_MASK) begin
        irq_mask <= wr_data[2:0];
      end
    end
  end

  // Set wins over a write-one clear in the same cycle
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_status <= `TCO_RST_IRQ;
      irq_out <= 1'b0;
    end else begin
      if (wr_do && wr_idx == `TCO_IDX_IRQ_STATUS) begin
        irq_status <= (irq_status & ~wr_data[2:0]) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
      irq_out <= |(irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  reg [7:0] rd_byte;
  reg rd_hit;
  wire [9:0] rd_idx;

  assign rd_idx = s_axi_araddr_in[11:2];

  always @* begin
    rd_hit = 1'b1;
    if (rd_idx == `TCO_IDX_A_CMPB_LO) begin
      rd_byte = timer_a_compare_b_value[7:0];
    end else if (rd_idx == `TCO_IDX_A_CMPB_HI) begin
      rd_byte = timer_a_compare_b_value[15:8];
    end else if (rd_idx == `TCO_IDX_B_CTRL_A) begin
      rd_byte = timer_b_control_a;
    end else if (rd_idx == `TCO_IDX_B_CTRL_B) begin
      rd_byte = timer_b_control_b;
    end else if (rd_idx == `TCO_IDX_B_CMPA_LO) begin
      rd_byte = timer_b_compare_a_value[7:0];
    end else if (rd_idx == `TCO_IDX_B_CMPA_HI) begin
      rd_byte = timer_b_compare_a_value[15:8];
    end else if (rd_idx == `TCO_IDX_B_CMPB_LO) begin
      rd_byte = timer_b_compare_b_value[7:0];
    end else if (rd_idx == `TCO_IDX_B_CMPB_HI) begin
      rd_byte = timer_b_compare_b_value[15:8];
    end else if (rd_idx == `TCO_IDX_A_MODE) begin
      rd_byte = {6'h00, timer_a_b_mode};
    end else if (rd_idx == `TCO_IDX_IRQ_STATUS) begin
      rd_byte = {5'h00, irq_status};
    end else if (rd_idx == `TCO_IDX_IRQ_MASK) begin
      rd_byte = {5'h00, irq_mask};
    end else begin
      rd_byte = 8'h00;
      rd_hit = 1'b0;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= `TCO_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= {24'h000000, rd_byte};
      s_axi_rresp_out <= rd_hit ? `TCO_RESP_OKAY : `TCO_RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Waveform mode decode
  // ----------------------------------------------------------------
  wire [3:0] waveform_mode;
  wire fast_pwm;
  wire phase_pwm;
  wire toggle_ok_fast;
  wire toggle_ok_phase;
  wire [15:0] b_cmp [0:1];
  wire [1:0] b_mode [0:1];
  wire [1:0] b_dir;
  wire [1:0] b_state;
  wire [1:0] b_conn;

  assign waveform_mode = {timer_b_control_b[`TCO_WAVE_UP_HI:
    `TCO_WAVE_UP_LO], timer_b_control_a[`TCO_WAVE_LOW_HI:
    `TCO_WAVE_LOW_LO]};
  assign fast_pwm = (waveform_mode == 4'h5) | (waveform_mode == 4'h6) |
    (waveform_mode == 4'h7) | (waveform_mode == 4'hE) |
    (waveform_mode == 4'hF);
  assign phase_pwm = (waveform_mode != 4'h0) & (waveform_mode < 4'h4) |
    (waveform_mode[3:2] == 2'h2);
  assign toggle_ok_fast = (waveform_mode == 4'hE) |
    (waveform_mode == 4'hF);
  assign toggle_ok_phase = (waveform_mode == 4'h9) |
    (waveform_mode == 4'hB);
  assign b_cmp[0] = timer_b_compare_a_value;
  assign b_cmp[1] = timer_b_compare_b_value;
  assign b_mode[0] = timer_b_control_a[`TCO_CHA_MODE_HI:
    `TCO_CHA_MODE_LO];
  assign b_mode[1] = timer_b_control_a[`TCO_CHB_MODE_HI:
    `TCO_CHB_MODE_LO];
  assign b_dir = {port_dir_b_out_b_in, port_dir_b_out_a_in};

  // ----------------------------------------------------------------
  // Timer B compare output units, one per channel
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      reg oc_state;
      reg conn;
      reg next_oc;
      wire at_bottom;
      wire toggle_ok;

      assign at_bottom = timer_b_tick_in & (timer_b_counter_in == 16'h0000);
      // In PWM modes, mode 01 toggle exists for channel A only
      assign toggle_ok = (ch == 0) &
        (fast_pwm ? toggle_ok_fast : toggle_ok_phase);
      assign b_state[ch] = oc_state;
      assign b_conn[ch] = conn;

      always @* begin
        next_oc = oc_state;
        conn = (b_mode[ch] != `TCO_MODE_OFF);
        if (fast_pwm) begin
          if (b_mode[ch] == `TCO_MODE_TOGGLE) begin
            conn = toggle_ok;
            if (toggle_ok && b_match[ch]) begin
              next_oc = ~oc_state;
            end
          end else if (b_mode[ch][1]) begin
            if (at_bottom) begin
              next_oc = ~b_mode[ch][0];
            end
            if (b_match[ch] && b_cmp[ch] != timer_b_top_in) begin
              next_oc = b_mode[ch][0];
            end
          end
        end else if (phase_pwm) begin
          if (b_mode[ch] == `TCO_MODE_TOGGLE) begin
            conn = toggle_ok;
            if (toggle_ok && b_match[ch]) begin
              next_oc = ~oc_state;
            end
          end else if (b_mode[ch][1] && b_match[ch]) begin
            next_oc = b_mode[ch][0] ~^ timer_b_count_up_in;
          end
        end else if (b_match[ch]) begin
          if (b_mode[ch] == `TCO_MODE_TOGGLE) begin
            next_oc = ~oc_state;
          end else if (b_mode[ch][1]) begin
            next_oc = b_mode[ch][0];
          end
        end
      end

      // Held while disconnected so reconnecting resumes the level
      always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          oc_state <= 1'b0;
        end else begin
          oc_state <= next_oc;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Timer A channel B output, non-PWM only
  // ----------------------------------------------------------------
  reg a_state;
  wire a_conn;

  assign a_conn = (timer_a_b_mode != `TCO_MODE_OFF);

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      a_state <= 1'b0;
    end else if (a_match) begin
      if (timer_a_b_mode == `TCO_MODE_TOGGLE) begin
        a_state <= ~a_state;
      end else if (timer_a_b_mode[1]) begin
        a_state <= timer_a_b_mode[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  wire b_gate;

  // Channel B pins share port D bit 2 as an extra enable
  assign b_gate = modulator_in_use_in | port_d_bit2_output_in;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_b_out_a_out <= 1'b0;
      timer_b_out_a_override_out <= 1'b0;
      timer_b_out_a_oe_out <= 1'b0;
      timer_b_out_b_out <= 1'b0;
      timer_b_out_b_override_out <= 1'b0;
      timer_b_out_b_oe_out <= 1'b0;
      timer_a_out_b_out <= 1'b0;
      timer_a_out_b_override_out <= 1'b0;
      timer_a_out_b_oe_out <= 1'b0;
    end else begin
      timer_b_out_a_out <= b_state[0];
      timer_b_out_a_override_out <= b_conn[0];
      timer_b_out_a_oe_out <= b_conn[0] & b_dir[0];
      timer_b_out_b_out <= b_state[1];
      timer_b_out_b_override_out <= b_conn[1];
      timer_b_out_b_oe_out <= b_conn[1] & b_dir[1] & b_gate;
      timer_a_out_b_out <= a_state;
      timer_a_out_b_override_out <= a_conn;
      timer_a_out_b_oe_out <= a_conn & port_dir_a_out_b_in &
        b_gate;
    end
  end

endmodule // tco_ctrl

// File: verif/tco_pin_model.sv
`timescale 1ns/1ns
// --------------------------------
// Port pin with pull-up
// --------------------------------
module tco_pin_model (
  input wire drive_in,
  input wire override_in,
  input wire oe_in,
  input wire port_data_in,
  output wire pin_out
);
  // Undriven pin reads the pull-up, never the last driven level
  assign pin_out = oe_in ? (override_in ? drive_in : port_data_in) : 1'h1;
endmodule // tco_pin_model

// File: verif/tco_ctrl_asserts.sv
`timescale 1ns/1ns
module tco_ctrl_asserts (
  input wire clk_in,
  input wire nrst_in,
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire s_axi_rvalid_out,
  input wire timer_a_tick_in,
  input wire timer_b_tick_in,
  input wire port_dir_b_out_a_in,
  input wire port_dir_b_out_b_in,
  input wire port_d_bit2_output_in,
  input wire modulator_in_use_in,
  input wire timer_b_out_a_out,
  input wire timer_b_out_b_out,
  input wire timer_a_out_b_out,
  input wire timer_b_out_a_oe_out,
  input wire timer_b_out_b_oe_out
);
  default clocking cb_clk @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  sequence s_wr_taken;
    s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  wr_answer_a:
    assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid_out)
    else $error("late write response");
  rd_answer_a:
    assert property (s_rd_taken |=> s_axi_rvalid_out)
    else $error("late read response");
  rd_block_a:
    assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted while answering");
  wr_block_a:
    assert property (s_axi_bvalid_out |->
      !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while answering");
  gate_dir_a:
    assert property (timer_b_out_a_oe_out |-> $past(port_dir_b_out_a_in))
    else $error("driver on without direction");
  gate_port_a:
    assert property (timer_b_out_b_oe_out |-> $past(port_dir_b_out_b_in &&
      (port_d_bit2_output_in || modulator_in_use_in)))
    else $error("channel B driver on without gate");
  reset_low_a:
    assert property ($rose(nrst_in) |-> !timer_b_out_a_out &&
      !timer_b_out_b_out && !timer_a_out_b_out)
    else $error("output state not low after reset");
  b_out_a_cause_a:
    assert property ($changed(timer_b_out_a_out) |->
      $past(timer_b_tick_in, 2))
    else $error("channel A moved without a tick");
  b_out_b_cause_a:
    assert property ($changed(timer_b_out_b_out) |->
      $past(timer_b_tick_in, 2))
    else $error("channel B moved without a tick");
  a_out_cause_a:
    assert property ($changed(timer_a_out_b_out) |->
      $past(timer_a_tick_in, 2))
    else $error("timer A output moved without a tick");
endmodule // tco_ctrl_asserts

// File: verif/tco_ctrl_tb_top.sv
`timescale 1ns/1ns
`include "tco_regs.vh"
module tco_ctrl_tb_top;
  logic clk_in = 1'h0;
  logic nrst_in = 1'h0;
  logic [11:0] s_axi_awaddr_in = 12'h0, s_axi_araddr_in = 12'h0;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0;
  logic s_axi_bready_in = 1'h0, s_axi_arvalid_in = 1'h0;
  logic s_axi_rready_in = 1'h0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out;
  logic [15:0] timer_a_counter_in = 16'h0, timer_b_counter_in = 16'h0;
  logic [15:0] timer_b_top_in = 16'h0;
  logic timer_a_tick_in = 1'h0, timer_b_tick_in = 1'h0;
  logic timer_b_count_up_in = 1'h1, modulator_in_use_in = 1'h0;
  logic port_dir_b_out_a_in = 1'h1, port_dir_b_out_b_in = 1'h1;
  logic port_dir_a_out_b_in = 1'h1, port_d_bit2_output_in = 1'h1;
  logic timer_b_out_a_out, timer_b_out_a_override_out, timer_b_out_a_oe_out;
  logic timer_b_out_b_out, timer_b_out_b_override_out, timer_b_out_b_oe_out;
  logic timer_a_out_b_out, timer_a_out_b_override_out, timer_a_out_b_oe_out;
  logic irq_out, pin_b;
  int mismatches = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h14CE;
  logic [31:0] r;
  logic [15:0] c, v;
  logic sa = 1'h0;
  logic sb = 1'h0;
  // Bits: control B, control A, bottom, up-count, compare at TOP
  logic [18:0] steps [15] = '{
    {8'h00, 8'h50, 3'h2}, {8'h00, 8'hF0, 3'h2}, {8'h00, 8'hA0, 3'h2},
    {8'h00, 8'h50, 3'h2}, {8'h00, 8'h00, 3'h2}, {8'h18, 8'hB2, 3'h6},
    {8'h18, 8'hB2, 3'h2}, {8'h18, 8'hB2, 3'h7}, {8'h18, 8'hB2, 3'h3},
    {8'h18, 8'h52, 3'h2}, {8'h08, 8'h51, 3'h2}, {8'h10, 8'h51, 3'h2},
    {8'h00, 8'h51, 3'h2}, {8'h10, 8'hB3, 3'h2}, {8'h10, 8'hB3, 3'h0}};

  tco_ctrl u_dut (.*);
  tco_pin_model u_pin_b (
    .drive_in(timer_b_out_b_out),
    .override_in(timer_b_out_b_override_out),
    .oe_in(timer_b_out_b_oe_out),
    .port_data_in(port_d_bit2_output_in),
    .pin_out(pin_b)
  );

  always #10 clk_in = ~clk_in;

  // --------------------------------
  // Helpers
  // --------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Returns {connected, next output state}
  function automatic logic [1:0] ref_pin(input logic [3:0] w,
      input logic [1:0] m, input logic a, mt, bot, up, teq, prev);
    logic fast, ph;
    fast = w inside {4'h5, 4'h6, 4'h7, 4'hE, 4'hF};
    ph = w inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
    if (m == 2'h1 && fast && !(a && w[3:1] == 3'h7))
      m = 2'h0;
    if (m == 2'h1 && ph && !(a && (w == 4'h9 || w == 4'hB)))
      m = 2'h0;
    ref_pin = {m != 2'h0, prev};
    if (m == 2'h0)
      return ref_pin;
    if (fast && m[1]) begin
      if (bot)
        ref_pin[0] = ~m[0];
      if (mt && !teq)
        ref_pin[0] = m[0];
    end else if (ph && m[1]) begin
      if (mt)
        ref_pin[0] = up ? m[0] : ~m[0];
    end else if (mt) begin
      ref_pin[0] = m[1] ? m[0] : ~prev;
    end
  endfunction

  task automatic chk(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d,
      input logic [1:0] resp = `TCO_RESP_OKAY);
    s_axi_awaddr_in <= {idx, 2'h0};
    s_axi_wdata_in <= {24'h0, d};
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    do begin
      @(posedge clk_in);
      if (s_axi_awready_out)
        s_axi_awvalid_in <= 1'h0;
      if (s_axi_wready_out)
        s_axi_wvalid_in <= 1'h0;
    end while (s_axi_bvalid_out !== 1'h1);
    s_axi_bready_in <= 1'h0;
    chk(s_axi_bresp_out, resp);
    @(posedge clk_in);
  endtask

  task automatic rchk(input logic [9:0] idx, input logic [7:0] exp,
      input logic [1:0] resp = `TCO_RESP_OKAY);
    s_axi_araddr_in <= {idx, 2'h0};
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    do begin
      @(posedge clk_in);
      if (s_axi_arready_out)
        s_axi_arvalid_in <= 1'h0;
    end while (s_axi_rvalid_out !== 1'h1);
    s_axi_rready_in <= 1'h0;
    chk(s_axi_rresp_out, resp);
    chk(s_axi_rdata_out, {24'h0, exp});
    @(posedge clk_in);
  endtask

  // One tick, then two edges for the state to reach the pins
  task automatic hit(input logic ta, input logic [15:0] cnt, input logic up);
    if (ta)
      timer_a_counter_in <= cnt;
    else
      timer_b_counter_in <= cnt;
    timer_a_tick_in <= ta;
    timer_b_tick_in <= !ta;
    timer_b_count_up_in <= up;
    @(posedge clk_in);
    timer_a_tick_in <= 1'h0;
    timer_b_tick_in <= 1'h0;
    repeat (2) @(posedge clk_in);
  endtask

  task automatic step(input logic [7:0] cb, ca, input logic bot, up, teq);
    logic [31:0] q;
    logic [1:0] ra, rb;
    q = rnd();
    timer_b_top_in <= teq ? c : ~c;
    port_dir_b_out_a_in <= q[0];
    port_dir_b_out_b_in <= q[1];
    port_d_bit2_output_in <= q[2];
    modulator_in_use_in <= q[3];
    wr(`TCO_IDX_B_CTRL_B, cb);
    wr(`TCO_IDX_B_CTRL_A, ca);
    hit(1'h0, bot ? 16'h0 : c, up);
    ra = ref_pin({cb[4:3], ca[1:0]}, ca[7:6], 1'h1, !bot, bot, up, teq, sa);
    rb = ref_pin({cb[4:3], ca[1:0]}, ca[5:4], 1'h0, !bot, bot, up, teq, sb);
    sa = ra[0];
    sb = rb[0];
    chk(timer_b_out_a_out, ra[0]);
    chk(timer_b_out_b_out, rb[0]);
    chk(timer_b_out_a_override_out, ra[1]);
    chk(timer_b_out_b_override_out, rb[1]);
    chk(timer_b_out_a_oe_out, ra[1] & q[0]);
    chk(pin_b, (rb[1] & q[1] & (q[2] | q[3])) ? rb[0] : 1'h1);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // --------------------------------
  // Sequence
  // --------------------------------
  initial begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'h1;
    @(posedge clk_in);
    chk(timer_b_out_a_out, 1'h0);
    rchk(`TCO_IDX_B_CTRL_A, 8'h00);
    wr(`TCO_IDX_B_CTRL_A, 8'hFF);
    rchk(`TCO_IDX_B_CTRL_A, 8'hF3);
    wr(`TCO_IDX_B_CTRL_B, 8'h18);
    rchk(`TCO_IDX_B_CTRL_B, 8'h18);
    // Lane 0 strobe low: response is OKAY but nothing lands
    s_axi_wstrb_in <= 4'hE;
    wr(`TCO_IDX_B_CTRL_B, 8'h00);
    s_axi_wstrb_in <= 4'hF;
    rchk(`TCO_IDX_B_CTRL_B, 8'h18);
    wr(10'h3FF, 8'h5A, `TCO_RESP_SLVERR);
    rchk(10'h3FF, 8'h00, `TCO_RESP_SLVERR);
    r = rnd();
    v = r[15:0];
    wr(`TCO_IDX_A_CMPB_HI, v[15:8]);
    rchk(`TCO_IDX_A_CMPB_HI, 8'h00);
    wr(`TCO_IDX_A_CMPB_LO, v[7:0]);
    rchk(`TCO_IDX_A_CMPB_HI, v[15:8]);
    wr(`TCO_IDX_A_MODE, 8'h01);
    hit(1'h1, v, 1'h1);
    chk(timer_a_out_b_out, 1'h1);
    chk(timer_a_out_b_oe_out, 1'h1);
    hit(1'h1, ~v, 1'h1);
    chk(timer_a_out_b_out, 1'h1);
    port_d_bit2_output_in <= 1'h0;
    hit(1'h1, v, 1'h1);
    chk(timer_a_out_b_out, 1'h0);
    chk(timer_a_out_b_oe_out, 1'h0);
    chk(timer_a_out_b_override_out, 1'h1);
    wr(`TCO_IDX_A_MODE, 8'h03);
    hit(1'h1, v, 1'h1);
    chk(timer_a_out_b_out, 1'h1);
    wr(`TCO_IDX_A_MODE, 8'h00);
    hit(1'h1, v, 1'h1);
    chk(timer_a_out_b_out, 1'h1);
    chk(timer_a_out_b_override_out, 1'h0);
    r = rnd();
    c = r[15:0] | 16'h1;
    wr(`TCO_IDX_B_CMPA_HI, c[15:8]);
    wr(`TCO_IDX_B_CMPA_LO, c[7:0]);
    wr(`TCO_IDX_B_CMPB_HI, c[15:8]);
    wr(`TCO_IDX_B_CMPB_LO, c[7:0]);
    for (int i = 0; i < 15; i++)
      step(steps[i][18:11], steps[i][10:3], steps[i][2], steps[i][1],
        steps[i][0]);
    repeat (24) begin
      r = rnd();
      step(r[7:0] & 8'h18, r[15:8], r[16], r[17], r[18]);
    end
    wr(`TCO_IDX_IRQ_STATUS, 8'h07);
    wr(`TCO_IDX_IRQ_MASK, 8'h02);
    rchk(`TCO_IDX_IRQ_STATUS, 8'h00);
    chk(irq_out, 1'h0);
    step(8'h00, 8'hF0, 1'h0, 1'h1, 1'h0);
    rchk(`TCO_IDX_IRQ_STATUS, 8'h06);
    chk(irq_out, 1'h1);
    wr(`TCO_IDX_IRQ_STATUS, 8'h02);
    rchk(`TCO_IDX_IRQ_STATUS, 8'h04);
    chk(irq_out, 1'h0);
    wr(`TCO_IDX_IRQ_MASK, 8'h04);
    rchk(`TCO_IDX_IRQ_MASK, 8'h04);
    chk(irq_out, 1'h1);
    print_verdict();
  end

  // Whole run is under a thousand cycles; this only catches a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    print_verdict();
  end
endmodule // tco_ctrl_tb_top

bind tco_ctrl tco_ctrl_asserts u_chk (.*);
